// ===== core/octal_out_ctrl.sv
// Output control of an eight-channel 12-bit converter: sleep, control port, serial lanes.
// Assumes samples arrive on link_clk from the conversion core; rst_n is synchronous to clk.
// Summary of operation
// - While reset is low all digital state and the analog core are put to reset.
// - A high sleep pin puts the device to sleep and stops conversion.
// - After sleep goes low the outputs resume only once the exit interval has run out.
// - Eight differential lanes, each carrying only its own channel.
// - Lanes start in reduced common mode LVDS; a register write selects SLVS or LVDS.
// - Bit 4 of the output control register switches on 100 ohm lane and clock termination.
// - A differential bit clock goes with the lanes and is used by the receiver to sample.
// - A differential word clock marks each frame; the receiver aligns words to it.
// - The single control data pin carries address and data in and read data out.
module octal_out_ctrl
    import octal_out_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic sleep_pin,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sclk_pin,
    input wire logic ssel_n_pin,
    input wire logic sdata_i,
    output logic sdata_o,
    output logic sdata_oe,
    output logic core_rst_n,
    output logic core_sleep,
    output logic [1:0] out_fmt,
    output logic term_en,
    input wire logic [LANES-1:0][SAMPLE_BITS-1:0] sample_word,
    output logic sample_take,
    output logic [LANES-1:0] sample_lane_p,
    output logic [LANES-1:0] sample_lane_n,
    output logic bclk_p,
    output logic bclk_n,
    output logic wclk_p,
    output logic wclk_n
);
    // =========================================
    // Register read decode, shared by the bus and the control port
    logic [1:0] fmt_ff;
    logic term_ff;
    logic sleep_ff;
    logic running_ff;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == REG_OUT_CTRL) begin
            v[FMT_MSB:FMT_LSB] = fmt_ff;
            v[TERM_BIT] = term_ff;
        end else if (a == REG_STATUS) begin
            v[ST_SLEEP_BIT] = sleep_ff;
            v[ST_RUN_BIT] = running_ff;
        end
        return v;
    endfunction : reg_read

    // =========================================
    // Pin synchronisers: three stages, a change counts when stages two and three agree
    logic [2:0] s1_ff, s2_ff, s3_ff, flt_ff;
    logic [2:0] nxt_flt;
    always_ff @(posedge clk) begin
        s1_ff <= {sleep_pin, ssel_n_pin, sclk_pin};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_flt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flt_ff[i];
        end
    end
    // Select idles high so no transaction starts out of reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flt_ff <= 3'h2;
        end else begin
            flt_ff <= nxt_flt;
        end
    end
    logic sclk_rise, sclk_fall, ssel_q, sdat1_ff, sdat2_ff;
    assign sclk_rise = nxt_flt[0] & ~flt_ff[0];
    assign sclk_fall = ~nxt_flt[0] & flt_ff[0];
    assign ssel_q = flt_ff[1];
    // Data is stable around the clock edge; two stages keep it aligned with the filtered clock
    always_ff @(posedge clk) begin
        sdat1_ff <= sdata_i;
        sdat2_ff <= sdat1_ff;
    end

    // =========================================
    // Control port: 8 command bits (read flag, 7 address bits), then 8 data bits
    spi_state_t st_ff;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    logic [7:0] rsh_ff;
    logic spi_wr;
    logic [7:0] spi_addr_ff;
    assign spi_wr = (st_ff == SPI_WRITE) && sclk_rise && (bit_ff == SPI_LAST_BIT);
    always_ff @(posedge clk) begin
        if (!rst_n || ssel_q) begin
            st_ff <= SPI_IDLE;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            spi_addr_ff <= 8'h00;
        end else begin
            case (st_ff)
                SPI_IDLE: begin
                    st_ff <= SPI_CMD;
                    bit_ff <= 3'h0;
                end
                SPI_CMD, SPI_WRITE: begin
                    if (sclk_rise) begin
                        sh_ff <= {sh_ff[6:0], sdat2_ff};
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == SPI_LAST_BIT && st_ff == SPI_CMD) begin
                            spi_addr_ff <= {1'b0, sh_ff[5:0], sdat2_ff};
                            st_ff <= sh_ff[SPI_RW_BIT-1] ? SPI_READ : SPI_WRITE;
                        end else if (bit_ff == SPI_LAST_BIT) begin
                            st_ff <= SPI_DONE;
                        end
                    end
                end
                default: begin
                    st_ff <= st_ff;
                end
            endcase
        end
    end
    // Pin turns around only after the command phase; released as soon as select rises
    always_ff @(posedge clk) begin
        if (!rst_n || ssel_q) begin
            sdata_oe <= 1'b0;
            sdata_o <= 1'b0;
            rsh_ff <= 8'h00;
        end else if (st_ff == SPI_CMD && sclk_rise && bit_ff == SPI_LAST_BIT) begin
            rsh_ff <= reg_read({1'b0, sh_ff[5:0], sdat2_ff});
        end else if (st_ff == SPI_READ && sclk_fall) begin
            sdata_oe <= 1'b1;
            sdata_o <= rsh_ff[7];
            rsh_ff <= {rsh_ff[6:0], 1'b0};
        end
    end

    // =========================================
    // Output control register; the parallel bus wins a same-cycle clash
    logic ctrl_we;
    logic [7:0] ctrl_wd;
    assign ctrl_we = (wr && addr == REG_OUT_CTRL) || (spi_wr && spi_addr_ff == REG_OUT_CTRL);
    assign ctrl_wd = (wr && addr == REG_OUT_CTRL) ? wdata : {sh_ff[6:0], sdat2_ff};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fmt_ff <= FMT_RCM_LVDS;
            term_ff <= 1'b0;
        end else if (ctrl_we) begin
            term_ff <= ctrl_wd[TERM_BIT];
            // The reserved format code is ignored so the driver never sees it
            if (ctrl_wd[FMT_MSB:FMT_LSB] != FMT_RSVD) begin
                fmt_ff <= ctrl_wd[FMT_MSB:FMT_LSB];
            end
        end
    end
    assign out_fmt = fmt_ff;
    assign term_en = term_ff;

    // Bus read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n || !rd) begin
            rdata <= 8'h00;
        end else begin
            rdata <= reg_read(addr);
        end
    end

    // =========================================
    // Sleep entry and exit timing
    logic [8:0] exit_cnt_ff;
    logic rst_q_ff;
    always_ff @(posedge clk) begin
        rst_q_ff <= rst_n;
        if (!rst_n) begin
            sleep_ff <= 1'b0;
            exit_cnt_ff <= 9'h000;
            running_ff <= 1'b0;
        end else begin
            sleep_ff <= flt_ff[2];
            if (flt_ff[2]) begin
                exit_cnt_ff <= SLEEP_EXIT_LD;
            end else if (exit_cnt_ff != 9'h000) begin
                exit_cnt_ff <= exit_cnt_ff - 9'h001;
            end
            running_ff <= !flt_ff[2] && !sleep_ff && exit_cnt_ff == 9'h000;
        end
    end
    assign core_sleep = sleep_ff;
    assign core_rst_n = rst_q_ff;

    // =========================================
    // Link domain: reset and run enable cross as levels through two stages
    logic lrst_q1_ff, lrst_n_ff, run_q1_ff, run_l_ff;
    always_ff @(posedge link_clk) begin
        lrst_q1_ff <= rst_n;
        lrst_n_ff <= lrst_q1_ff;
        run_q1_ff <= running_ff;
        run_l_ff <= run_q1_ff;
    end

    // Bit clock runs at half the link clock; data moves as it falls so it is centred on the rise
    logic bclk_ff, wclk_ff, frame_end;
    logic [3:0] slot_ff, nxt_slot;
    assign frame_end = slot_ff == LAST_SLOT;
    assign nxt_slot = frame_end ? 4'h0 : slot_ff + 4'h1;
    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff || !run_l_ff) begin
            bclk_ff <= 1'b0;
            slot_ff <= LAST_SLOT;
            wclk_ff <= 1'b0;
        end else begin
            bclk_ff <= ~bclk_ff;
            if (bclk_ff) begin
                slot_ff <= nxt_slot;
                wclk_ff <= nxt_slot < WCLK_SLOTS;
            end
        end
    end

    // Lane shifters: one sample word per lane and frame, MSB first
    logic [LANES-1:0][SAMPLE_BITS-1:0] shf_ff, shl;
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            shl[i] = {shf_ff[i][SAMPLE_BITS-2:0], 1'b0};
        end
    end
    assign sample_take = run_l_ff && lrst_n_ff && bclk_ff && frame_end;
    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff || !run_l_ff) begin
            shf_ff <= '0;
        end else if (sample_take) begin
            shf_ff <= sample_word;
        end else if (bclk_ff) begin
            shf_ff <= shl;
        end
    end
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            sample_lane_p[i] = shf_ff[i][SAMPLE_BITS-1];
        end
    end
    assign sample_lane_n = ~sample_lane_p;
    assign bclk_p = bclk_ff;
    assign bclk_n = ~bclk_ff;
    assign wclk_p = wclk_ff;
    assign wclk_n = ~wclk_ff;

    // =========================================
    // Checks
    property p_reset_state;
        @(posedge clk) !rst_n |=> fmt_ff == FMT_RCM_LVDS && !term_ff && !running_ff && !sdata_oe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");

    property p_fmt_write;
        @(posedge clk) disable iff (!rst_n)
        wr && addr == REG_OUT_CTRL && wdata[1:0] != FMT_RSVD |=> out_fmt == $past(wdata[1:0]);
    endproperty
    a_fmt_write: assert property (p_fmt_write) else $error("format write not applied");

    // A back-to-back write may legally change the bit again, so stability is only asked without one
    property p_term;
        @(posedge clk) disable iff (!rst_n)
        wr && addr == REG_OUT_CTRL |=> term_en == $past(wdata[TERM_BIT]) ##1 ($past(ctrl_we) || term_en == $past(term_en));
    endproperty
    a_term: assert property (p_term) else $error("termination bit wrong");

    property p_sleep;
        @(posedge clk) disable iff (!rst_n) $rose(flt_ff[2]) |=> core_sleep && !running_ff;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    property p_wake;
        @(posedge clk) disable iff (!rst_n) $fell(core_sleep) |-> !running_ff [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("woke before exit interval");

    property p_pin_dir;
        @(posedge clk) disable iff (!rst_n) sdata_oe |-> st_ff == SPI_READ;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("data pin driven outside read");

    // Enable is registered, so it drops one edge after the filtered select rises
    property p_pin_release;
        @(posedge clk) disable iff (!rst_n) ssel_q |=> !sdata_oe;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("data pin held after deselect");

    property p_bclk;
        @(posedge link_clk) disable iff (!lrst_n_ff) run_l_ff && $past(run_l_ff) |-> bclk_p != $past(bclk_p);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock stalled");

    // Link cycles since the last word clock rise; a counter keeps the frame check cheap to evaluate
    logic wclk_q_ff;
    logic [4:0] wclk_age_ff;
    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff || !run_l_ff) begin
            wclk_q_ff <= 1'b0;
            wclk_age_ff <= 5'h00;
        end else begin
            wclk_q_ff <= wclk_ff;
            if (wclk_ff && !wclk_q_ff) begin
                wclk_age_ff <= 5'h01;
            end else if (wclk_age_ff != 5'h00 && wclk_age_ff != 5'h1f) begin
                wclk_age_ff <= wclk_age_ff + 5'h01;
            end
        end
    end
    property p_frame;
        @(posedge link_clk) disable iff (!lrst_n_ff)
        wclk_ff != wclk_q_ff && wclk_age_ff != 5'h00 |->
            wclk_age_ff == (wclk_ff ? 5'(2 * SAMPLE_BITS) : 5'(SAMPLE_BITS));
    endproperty
    a_frame: assert property (p_frame) else $error("word clock period wrong");

    property p_msb;
        @(posedge link_clk) disable iff (!lrst_n_ff)
        sample_take && run_q1_ff && lrst_q1_ff |=>
            sample_lane_p[0] == $past(sample_word[0][11]) && wclk_p && sample_lane_n == ~sample_lane_p;
    endproperty
    a_msb: assert property (p_msb) else $error("frame not MSB first");

    c_spi_read: cover property (@(posedge clk) disable iff (!rst_n) $fell(sdata_oe));
    c_wake: cover property (@(posedge clk) disable iff (!rst_n) $rose(running_ff) ##0 $past(exit_cnt_ff) == 9'h000);
    c_frame: cover property (@(posedge link_clk) disable iff (!lrst_n_ff) sample_take ##24 sample_take);
endmodule : octal_out_ctrl

// ===== core/octal_out_pkg.sv
// Constants and types for the octal converter output control block.
// Assumes a 200 MHz register clock and a free-running link clock from the PLL.
package octal_out_pkg;
    // =========================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int RST_MIN_NS = 500;
    localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SLEEP_EXIT_NS = 2000;
    localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [8:0] SLEEP_EXIT_LD = 9'(SLEEP_EXIT_CYC);
    // =========================================
    // Register map and fields
    localparam logic [7:0] REG_OUT_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam int FMT_LSB = 0;
    localparam int FMT_MSB = 1;
    localparam int TERM_BIT = 4;
    localparam logic [1:0] FMT_RCM_LVDS = 2'h0;
    localparam logic [1:0] FMT_SLVS = 2'h1;
    localparam logic [1:0] FMT_LVDS = 2'h2;
    localparam logic [1:0] FMT_RSVD = 2'h3;
    localparam int ST_SLEEP_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    // =========================================
    // Link framing
    localparam int LANES = 8;
    localparam int SAMPLE_BITS = 12;
    localparam logic [3:0] LAST_SLOT = 4'hb;
    localparam logic [3:0] WCLK_SLOTS = 4'h6;
    // =========================================
    // Control port framing
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam int SPI_RW_BIT = 7;
    typedef enum logic [2:0] {SPI_IDLE, SPI_CMD, SPI_WRITE, SPI_READ, SPI_DONE} spi_state_t;
endpackage : octal_out_pkg

// ===== tb/lane_receiver.sv
// Behavioural deserializing receiver at the far end of the eight sample lanes.
// Assumes bit and word clocks come from the converter; it only listens.
module lane_receiver
    import octal_out_pkg::*;
(
    input wire logic bclk_p,
    input wire logic wclk_p,
    input wire logic [LANES-1:0] lane_p,
    output logic got,
    output logic [LANES-1:0][SAMPLE_BITS-1:0] word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [LANES-1:0][SAMPLE_BITS-1:0] shift_ff;
    logic arm_ff;
    int bit_cnt;
    realtime last_rise;
    initial begin
        last_rise = 0.0;
        got = 1'b0;
        arm_ff = 1'b0;
        bit_cnt = SAMPLE_BITS;
        word = '0;
    end
    // =========================================
    // Framing
    // Arm on the word clock edge itself, so a frame cut short by sleep never leaks into the next
    always @(posedge wclk_p) arm_ff = 1'b1;
    // Shift on each bit clock rise, MSB first, one word per frame
    always @(posedge bclk_p) begin
        got <= 1'b0;
        // A stalled bit clock means the frame was cut by sleep or reset; drop the partial word
        if ($realtime - last_rise > 100.0) bit_cnt = SAMPLE_BITS;
        last_rise = $realtime;
        if (arm_ff) begin
            bit_cnt = 0;
            arm_ff = 1'b0;
        end
        if (bit_cnt < SAMPLE_BITS) begin
            for (int l = 0; l < LANES; l++) shift_ff[l] = {shift_ff[l][SAMPLE_BITS-2:0], lane_p[l]};
            bit_cnt++;
            if (bit_cnt == SAMPLE_BITS) begin
                word = shift_ff;
                got <= 1'b1;
            end
        end
    end
endmodule : lane_receiver

// ===== tb/test_octal_out_ctrl.sv
// Self-checking bench for the octal output control block.
// Assumes lane_receiver at the lanes; the bench plays core, bus and control-port master.
module test_octal_out_ctrl;
    import octal_out_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, link_clk = 0, sleep_pin = 0, wr = 0, rd = 0;
    logic sclk_pin = 0, ssel_n_pin = 1, sdata_i = 0, take_seen = 0, got;
    logic [7:0] addr = '0, wdata = '0, rdata, d;
    logic sdata_o, sdata_oe, core_rst_n, core_sleep, term_en, sample_take;
    logic bclk_p, bclk_n, wclk_p, wclk_n;
    logic [1:0] out_fmt, fmt_exp;
    logic [LANES-1:0] sample_lane_p, sample_lane_n;
    logic [LANES-1:0][SAMPLE_BITS-1:0] sample_word, last_taken, frame_exp, got_word, rnd_w;
    logic [31:0] lfsr = 32'hf8dc;
    int mismatches = 0, num_checks = 0, frames_ok = 0, seen;
    octal_out_ctrl i_octal_out_ctrl (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .sleep_pin(sleep_pin),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sclk_pin(sclk_pin),
        .ssel_n_pin(ssel_n_pin), .sdata_i(sdata_i), .sdata_o(sdata_o), .sdata_oe(sdata_oe),
        .core_rst_n(core_rst_n), .core_sleep(core_sleep), .out_fmt(out_fmt), .term_en(term_en),
        .sample_word(sample_word), .sample_take(sample_take), .sample_lane_p(sample_lane_p),
        .sample_lane_n(sample_lane_n), .bclk_p(bclk_p), .bclk_n(bclk_n), .wclk_p(wclk_p), .wclk_n(wclk_n));
    lane_receiver i_lane_receiver (.bclk_p(bclk_p), .wclk_p(wclk_p), .lane_p(sample_lane_p), .got(got),
        .word(got_word));
    // =========================================
    // Clocks: link clock offset so the two domains never line up
    initial forever #2.5 clk = ~clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // =========================================
    // Helpers
    function automatic logic [LANES-1:0][SAMPLE_BITS-1:0] nw();
        logic [LANES-1:0][SAMPLE_BITS-1:0] w;
        for (int l = 0; l < LANES; l++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            w[l] = lfsr[11:0];
        end
        return w;
    endfunction : nw
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
        num_checks++;
        if (got_v !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got_v);
        end
    endtask : chk
    task tally_and_finish();
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    // Poll status until running; a run-out bound counts as a failure
    task wait_run(input int lim);
        for (int i = 0; i <= lim; i++) begin
            rd_reg(REG_STATUS, d);
            if (d[ST_RUN_BIT] === 1'b1) return;
        end
        chk("run_wait", 32'h1, 32'h0);
        tally_and_finish();
    endtask : wait_run
    // Mode 0 control-port frame: data set while clock low, device samples on rise
    task spi_xfer(input logic [7:0] cmd, input logic [7:0] din, output logic [7:0] dout);
        logic [15:0] fr;
        fr = {cmd, din};
        @(posedge clk);
        ssel_n_pin <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (5) @(posedge clk);
            @(negedge clk);
            if (i < 8) dout[i] = sdata_o;
            chk("sdata_oe", {31'h0, cmd[7] && i < 8}, {31'h0, sdata_oe});
            @(posedge clk);
            sdata_i <= fr[i];
            repeat (6) @(posedge clk);
            sclk_pin <= 1'b1;
            repeat (6) @(posedge clk);
            sclk_pin <= 1'b0;
        end
        repeat (6) @(posedge clk);
        ssel_n_pin <= 1'b1;
        repeat (8) @(negedge clk);
        chk("sdata_oe_end", 32'h0, {31'h0, sdata_oe});
    endtask : spi_xfer
    task stream(input int n);
        seen = frames_ok;
        repeat (n * 24) @(posedge link_clk);
        chk("frames", 32'h1, {31'h0, frames_ok - seen >= n - 2});
    endtask : stream
    // =========================================
    // Sample source: a new word after every edge that consumed one
    initial sample_word = nw();
    always @(negedge link_clk) take_seen = sample_take;
    always @(posedge link_clk) begin
        if (take_seen) begin
            last_taken = sample_word;
            sample_word <= nw();
        end
    end
    always @(posedge wclk_p) frame_exp = last_taken;
    // Each received word must match its own lane's sample; pairs stay complementary
    always @(posedge got) begin
        #1;
        for (int l = 0; l < LANES; l++) chk("lane_word", {20'h0, frame_exp[l]}, {20'h0, got_word[l]});
        chk("lane_n", {22'h0, ~sample_lane_p, ~bclk_p, ~wclk_p}, {22'h0, sample_lane_n, bclk_n, wclk_n});
        frames_ok++;
    end
    // =========================================
    // Main sequence
    initial begin
        repeat (15) @(posedge clk);
        #1 chk("rst_outs", 32'h0, {26'h0, core_rst_n, core_sleep, sdata_oe, term_en, out_fmt});
        @(posedge clk);
        rst_n <= 1'b1;
        wait_run(20);
        chk("core_rst_n", 32'h1, {31'h0, core_rst_n});
        stream(6);
        fmt_exp = FMT_RCM_LVDS;
        for (int f = 0; f < 4; f++) begin
            rnd_w = nw();
            d = rnd_w[0][7:0];
            wr_reg(REG_OUT_CTRL, {3'h0, d[4], 2'h0, 2'(f)});
            if (f != 3) fmt_exp = 2'(f);
            chk("out_fmt", {30'h0, fmt_exp}, {30'h0, out_fmt});
            chk("term_en", {31'h0, d[4]}, {31'h0, term_en});
        end
        wr_reg(8'h05, 8'h01);
        chk("unmapped_wr", {30'h0, fmt_exp}, {30'h0, out_fmt});
        rd_reg(8'h7f, d);
        chk("unmapped_rd", 32'h0, {24'h0, d});
        spi_xfer(8'h00, {3'h0, 1'b1, 2'h0, FMT_SLVS}, d);
        chk("spi_wr", {29'h0, 1'b1, FMT_SLVS}, {29'h0, term_en, out_fmt});
        spi_xfer({1'b1, REG_STATUS[6:0]}, 8'h00, d);
        chk("spi_rd", 32'h2, {24'h0, d});
        stream(4);
        @(posedge clk);
        sleep_pin <= 1'b1;
        repeat (40) @(posedge link_clk);
        rd_reg(REG_STATUS, d);
        chk("sleep_st", 32'h1, {24'h0, d});
        chk("sleep_idle", 32'h200, {22'h0, core_sleep, sample_lane_p, bclk_p});
        @(posedge clk);
        sleep_pin <= 1'b0;
        repeat (SLEEP_EXIT_CYC - 10) @(posedge clk);
        rd_reg(REG_STATUS, d);
        chk("exit_early", 32'h0, {31'h0, d[ST_RUN_BIT]});
        wait_run(30);
        stream(5);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (100) @(posedge clk);
        #1 chk("mid_rst", 32'h0, {29'h0, core_rst_n, out_fmt});
        @(posedge clk);
        rst_n <= 1'b1;
        wait_run(20);
        stream(5);
        tally_and_finish();
    end
endmodule : test_octal_out_ctrl
